/* hdl/ctwc_pkg.sv */
package ctwc_pkg;
    localparam int CTWC_AW = 8;
    localparam logic [7:0] CTWC_OFS_SNS = 8'h00;
    localparam logic [7:0] CTWC_OFS_EIST = 8'h04;
    localparam logic [7:0] CTWC_OFS_ANCON = 8'h08;
    localparam logic [7:0] CTWC_OFS_EIEN = 8'h0C;
    localparam logic [7:0] CTWC_OFS_TSEL = 8'h10;
    localparam logic [7:0] CTWC_OFS_SCTL = 8'h14;
    localparam logic [7:0] CTWC_OFS_ISTAT = 8'h18;
    localparam logic [7:0] CTWC_OFS_IMASK = 8'h1C;
    localparam int CTWC_NTRG = 12;
    localparam int CTWC_NEI = 13;
    localparam int CTWC_NCORE = 6;
    localparam int CTWC_NDED = 5;
    localparam int CTWC_SHR = 5;
    localparam int CTWC_SHR_OFS = 7;
    localparam int CTWC_EN_LO = 0;
    localparam int CTWC_RDY_LO = 8;
    localparam int CTWC_IEN_LO = 16;
    localparam int CTWC_CNT_LO = 24;
    localparam int CTWC_EXP_W = 4;
    localparam logic [3:0] CTWC_MIN_EXP = 4'h4;
    localparam int CTWC_CNT_W = 16;
    localparam int CTWC_TSEL_W = 3;
    localparam int CTWC_TSEL_BITS = CTWC_NCORE * CTWC_TSEL_W;
    localparam int CTWC_IRQ_W = CTWC_NEI + CTWC_NCORE;
    localparam int CTWC_WK_IRQ_LO = CTWC_NEI;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [CTWC_AW-1:0] addr;
        logic [31:0] wdata;
    } ctwc_bus_t;

    typedef struct packed {
        logic busy;
        logic [CTWC_TSEL_W-1:0] left;
    } ctwc_prog_t;

    typedef struct packed {
        logic [CTWC_NTRG-1:0] trig_lvl;
        logic [CTWC_NTRG-1:0] trig_prev;
        logic [CTWC_NTRG-1:0] conv_start;
        logic scan_lvl;
        logic scan_prev;
        logic scan_start;
        logic [CTWC_NEI-1:0] early_flag;
        logic [CTWC_NEI-1:0] early_ien;
        logic [CTWC_TSEL_BITS-1:0] tsel;
        logic [CTWC_NCORE-1:0] an_en;
        logic [CTWC_NCORE-1:0] wk_ien;
        logic [CTWC_NCORE-1:0] wk_rdy;
        logic [CTWC_EXP_W-1:0] wk_exp;
        logic [CTWC_NCORE-1:0][CTWC_CNT_W-1:0] wk_cnt;
        logic [CTWC_IRQ_W-1:0] istat;
        logic [CTWC_IRQ_W-1:0] imask;
        logic irq;
        logic [31:0] rdata;
    } ctwc_state_t;
endpackage : ctwc_pkg

/* hdl/ctwc_top.sv */
// Contract
// [RULE_01] A set sensitivity bit makes its trigger level sensitive, restarting conversions while high.
// [RULE_02] A clear sensitivity bit, the reset value, reacts only to a rising trigger edge.
// [RULE_03] The sensitivity register holds bits 11 to 0; bits 31 to 12 read zero and ignore writes.
// [RULE_04] Third-class inputs start only from the scan trigger, edge or level per the scan level bit.
// [RULE_05] An early event sets the input's early-ready flag; it interrupts only if its enable is set.
// [RULE_06] Dedicated-core inputs time the early event from that core's select field, others from the shared one.
// [RULE_07] Early-ready flags for inputs 32 to 44 sit in bits 12 to 0, hardware set and cleared, reset zero.
// [RULE_08] Warm-up lasts two to the count field converter clocks, with codes up to 4 giving 16.
// [RULE_09] One count field in bits 27 to 24 serves all cores, each counting its own clocks.
// [RULE_10] After a core is enabled, its ready flag sets once the programmed clocks have passed.
// [RULE_11] Clearing a core's enable clears its ready flag at once.
// [RULE_12] A set warm-up interrupt enable raises an interrupt when that core's ready flag sets.
// [RULE_13] The shared core uses bits 7, 15 and 23; bits 6, 5, 14, 13, 22 and 21 read zero.
// [RULE_14] Edge detection keeps the previous trigger sample and fires on low to high.
// [RULE_15] Dropping an enable mid warm-up abandons the count; a new enable starts a full count.
`timescale 1ns/1ns
module ctwc_top
    import ctwc_pkg::*;
#(
    parameter logic [CTWC_NEI-1:0] DEDICATED = 13'h0000
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire ctwc_bus_t bus,
    output logic [31:0] rd_data,
    input wire logic [CTWC_NTRG-1:0] trig_in,
    input wire logic scan_trig_in,
    input wire ctwc_prog_t [CTWC_NEI-1:0] conv_prog,
    input wire logic [CTWC_NEI-1:0] result_read,
    input wire logic [CTWC_NCORE-1:0] core_tick,
    output logic [CTWC_NTRG-1:0] conv_start,
    output logic scan_start,
    output logic [CTWC_NCORE-1:0] warmup_ready,
    output logic [CTWC_NEI-1:0] early_ready,
    output logic irq
);

    ctwc_state_t st_q;
    ctwc_state_t st_next;
    logic [CTWC_NEI-1:0] early_ev;
    logic [CTWC_IRQ_W-1:0] irq_ev;

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [CTWC_CNT_W-1:0] ctwc_top_cnt(
        input logic [CTWC_EXP_W-1:0] e
    );
        logic [CTWC_EXP_W-1:0] ee;
        ee = (e < CTWC_MIN_EXP) ? CTWC_MIN_EXP : e; // RULE_08
        return (16'h0001 << ee) - 16'h0001;
    endfunction : ctwc_top_cnt

    // Per-core groups: cores 0-4 packed low, shared core at a fixed offset
    function automatic logic [CTWC_NCORE-1:0] ctwc_get6(
        input logic [31:0] w,
        input int lo
    );
        logic [31:0] s;
        s = w >> lo;
        return {s[CTWC_SHR_OFS], s[CTWC_NDED-1:0]};
    endfunction : ctwc_get6

    function automatic logic [31:0] ctwc_put6(
        input logic [31:0] w,
        input int lo,
        input logic [CTWC_NCORE-1:0] v
    );
        logic [31:0] r;
        r = w;
        r[lo +: CTWC_NDED] = v[CTWC_NDED-1:0];
        r[lo + CTWC_SHR_OFS] = v[CTWC_SHR];
        return r;
    endfunction : ctwc_put6

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic [31:0] w;
        logic [CTWC_IRQ_W-1:0] w1c;
        int core;
        w = 32'h0000_0000;
        w1c = '0;
        core = 0;
        st_next = st_q;
        early_ev = '0;
        irq_ev = '0;

        // Register writes; the warm-up logic below sees the new enables
        if (bus.wr)
        begin
            case (bus.addr)
                CTWC_OFS_SNS:
                    st_next.trig_lvl = bus.wdata[CTWC_NTRG-1:0]; // RULE_03
                CTWC_OFS_ANCON:
                begin
                    st_next.an_en = ctwc_get6(bus.wdata, CTWC_EN_LO);
                    st_next.wk_ien = ctwc_get6(bus.wdata, CTWC_IEN_LO);
                    st_next.wk_exp =
                        bus.wdata[CTWC_CNT_LO +: CTWC_EXP_W]; // RULE_09
                end
                CTWC_OFS_EIEN:
                    st_next.early_ien = bus.wdata[CTWC_NEI-1:0];
                CTWC_OFS_TSEL:
                    st_next.tsel = bus.wdata[CTWC_TSEL_BITS-1:0];
                CTWC_OFS_SCTL:
                    st_next.scan_lvl = bus.wdata[0];
                CTWC_OFS_ISTAT:
                    w1c = bus.wdata[CTWC_IRQ_W-1:0];
                CTWC_OFS_IMASK:
                    st_next.imask = bus.wdata[CTWC_IRQ_W-1:0];
                default:
                    w1c = '0;
            endcase
        end

        // Trigger sensitivity
        for (int i = 0; i < CTWC_NTRG; i++)
        begin
            st_next.trig_prev[i] = trig_in[i]; // RULE_14
            if (st_q.trig_lvl[i])
                st_next.conv_start[i] = trig_in[i]; // RULE_01
            else
                st_next.conv_start[i] =
                    trig_in[i] & ~st_q.trig_prev[i]; // RULE_02
        end
        st_next.scan_prev = scan_trig_in;
        st_next.scan_start = st_q.scan_lvl ? scan_trig_in :
            (scan_trig_in & ~st_q.scan_prev); // RULE_04

        // Early-ready flags; a new event wins over the read that clears
        for (int j = 0; j < CTWC_NEI; j++)
        begin
            core = DEDICATED[j] ? (j % CTWC_NDED) : CTWC_SHR; // RULE_06
            early_ev[j] = conv_prog[j].busy &&
                (conv_prog[j].left == st_q.tsel[core*CTWC_TSEL_W +:
                CTWC_TSEL_W]);
            st_next.early_flag[j] = early_ev[j] |
                (st_q.early_flag[j] & ~result_read[j]); // RULE_07
        end

        // Warm-up counters, each stepped by its own core's clock tick
        for (int k = 0; k < CTWC_NCORE; k++)
        begin
            if (!st_next.an_en[k])
            begin
                st_next.wk_rdy[k] = 1'b0; // RULE_11
                st_next.wk_cnt[k] = '0; // RULE_15
            end
            else if (!st_q.wk_rdy[k] && core_tick[k])
            begin
                if (st_q.wk_cnt[k] == ctwc_top_cnt(st_q.wk_exp))
                begin
                    st_next.wk_rdy[k] = 1'b1; // RULE_10
                    st_next.wk_cnt[k] = '0;
                end
                else
                    st_next.wk_cnt[k] = st_q.wk_cnt[k] + 16'h0001;
            end
        end

        irq_ev[CTWC_NEI-1:0] = early_ev & st_q.early_ien; // RULE_05
        irq_ev[CTWC_WK_IRQ_LO +: CTWC_NCORE] =
            st_next.wk_rdy & ~st_q.wk_rdy & st_q.wk_ien; // RULE_12
        st_next.istat = (st_q.istat & ~w1c) | irq_ev;
        st_next.irq = |(st_next.istat & st_next.imask);

        // Read data stands only in the cycle after the strobe
        st_next.rdata = 32'h0000_0000;
        if (bus.rd)
        begin
            case (bus.addr)
                CTWC_OFS_SNS:
                    st_next.rdata = 32'(st_q.trig_lvl); // RULE_03
                CTWC_OFS_EIST:
                    st_next.rdata = 32'(st_q.early_flag); // RULE_07
                CTWC_OFS_ANCON:
                begin
                    w = ctwc_put6(w, CTWC_EN_LO, st_q.an_en);
                    w = ctwc_put6(w, CTWC_RDY_LO, st_q.wk_rdy);
                    w = ctwc_put6(w, CTWC_IEN_LO, st_q.wk_ien);
                    w[CTWC_CNT_LO +: CTWC_EXP_W] = st_q.wk_exp;
                    st_next.rdata = w; // RULE_13
                end
                CTWC_OFS_EIEN:
                    st_next.rdata = 32'(st_q.early_ien);
                CTWC_OFS_TSEL:
                    st_next.rdata = 32'(st_q.tsel);
                CTWC_OFS_SCTL:
                    st_next.rdata = 32'(st_q.scan_lvl);
                CTWC_OFS_ISTAT:
                    st_next.rdata = 32'(st_q.istat);
                CTWC_OFS_IMASK:
                    st_next.rdata = 32'(st_q.imask);
                default:
                    st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_next;
    end

    assign rd_data = st_q.rdata;
    assign conv_start = st_q.conv_start;
    assign scan_start = st_q.scan_start;
    assign warmup_ready = st_q.wk_rdy;
    assign early_ready = st_q.early_flag;
    assign irq = st_q.irq;

    ////////////////////////////////////////////////////////////////////////

    a_level_retrig: assert property (@(posedge clk_sys) // RULE_01
        disable iff (rst)
        st_q.trig_lvl[0] && trig_in[0] ##1 st_q.trig_lvl[0] && trig_in[0]
        |=> conv_start[0] && $past(conv_start[0]))
        else $error("level trigger did not retrigger");

    a_edge_only: assert property (@(posedge clk_sys) // RULE_02 RULE_14
        disable iff (rst)
        !st_q.trig_lvl[0] && trig_in[0] && st_q.trig_prev[0]
        |=> !conv_start[0])
        else $error("edge trigger fired without a rising edge");

    a_sns_upper: assert property (@(posedge clk_sys) // RULE_03
        disable iff (rst)
        bus.rd && bus.addr == CTWC_OFS_SNS
        |=> rd_data[31:CTWC_NTRG] == '0)
        else $error("sensitivity upper bits not zero");

    a_scan_sens: assert property (@(posedge clk_sys) // RULE_04
        disable iff (rst)
        scan_trig_in && (st_q.scan_lvl || !st_q.scan_prev)
        |=> scan_start)
        else $error("scan trigger missed");

    a_early_set: assert property (@(posedge clk_sys) // RULE_05 RULE_06 RULE_07
        disable iff (rst)
        early_ev[0] |=> early_ready[0] && (!$past(st_q.early_ien[0]) ||
        st_q.istat[0]))
        else $error("early event not flagged");

    a_flag_clear: assert property (@(posedge clk_sys) // RULE_07
        disable iff (rst)
        result_read[0] && !early_ev[0] |=> !early_ready[0])
        else $error("early flag kept after result read");

    a_wk_time: assert property (@(posedge clk_sys) // RULE_08 RULE_10
        disable iff (rst)
        $rose(warmup_ready[0]) |-> $past(core_tick[0]) &&
        $past(st_q.wk_cnt[0]) == ctwc_top_cnt($past(st_q.wk_exp)))
        else $error("warm-up ready at wrong count");

    a_wk_hold: assert property (@(posedge clk_sys) // RULE_10
        disable iff (rst)
        warmup_ready[0] && st_next.an_en[0] |=> warmup_ready[0])
        else $error("warm-up ready dropped while enabled");

    a_wk_clear: assert property (@(posedge clk_sys) // RULE_11
        disable iff (rst)
        !st_q.an_en[0] |-> !warmup_ready[0] && st_q.wk_cnt[0] == '0)
        else $error("ready or count kept without enable");

    a_wk_restart: assert property (@(posedge clk_sys) // RULE_15
        disable iff (rst)
        $rose(st_q.an_en[0]) |-> st_q.wk_cnt[0] <= 16'h0001)
        else $error("warm-up count not restarted");

    a_ancon_zero: assert property (@(posedge clk_sys) // RULE_13
        disable iff (rst)
        bus.rd && bus.addr == CTWC_OFS_ANCON |=> rd_data[6:5] == '0 &&
        rd_data[14:13] == '0 && rd_data[22:21] == '0)
        else $error("reserved warm-up bits not zero");

    a_wk_irq: assert property (@(posedge clk_sys) // RULE_12
        disable iff (rst)
        $rose(warmup_ready[CTWC_SHR]) && $past(st_q.wk_ien[CTWC_SHR])
        |-> st_q.istat[CTWC_WK_IRQ_LO + CTWC_SHR])
        else $error("warm-up interrupt not raised");

    a_irq_set_wins: assert property (@(posedge clk_sys) // RULE_05
        disable iff (rst)
        irq_ev[0] |=> st_q.istat[0])
        else $error("early status lost to a same-cycle clear");

    a_irq_out: assert property (@(posedge clk_sys)
        disable iff (rst)
        irq == |(st_q.istat & st_q.imask))
        else $error("interrupt output disagrees with status");

    c_level_run: cover property (@(posedge clk_sys) disable iff (rst)
        conv_start[0] [*3]);
    c_wk_done: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(warmup_ready[CTWC_SHR]));
    c_early: cover property (@(posedge clk_sys) disable iff (rst)
        early_ev[0] && result_read[0]);
    c_irq: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(irq));
    c_abandon: cover property (@(posedge clk_sys) disable iff (rst)
        $fell(st_q.an_en[2]));

endmodule : ctwc_top

/* tb/ctwc_conv_model.sv */
`timescale 1ns/1ns
module ctwc_conv_model
    import ctwc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [CTWC_NCORE-1:0] tick_en,
    input wire logic [CTWC_NEI-1:0] go,
    output logic [CTWC_NCORE-1:0] core_tick,
    output ctwc_prog_t [CTWC_NEI-1:0] conv_prog
);
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            core_tick <= '0;
            conv_prog <= '0;
        end
        else
        begin
            // Each core steps only on its own enable line
            core_tick <= tick_en;
            for (int j = 0; j < CTWC_NEI; j++)
            begin
                // Counts start at 4, so a select of 5 to 7 never fires
                if (go[j])
                    conv_prog[j] <= '{busy: 1'b1, left: 3'h4};
                else if (conv_prog[j].busy && conv_prog[j].left != 3'h0)
                    conv_prog[j].left <= conv_prog[j].left - 3'h1;
                else
                    // Idle lines keep moving so a stale value never matches
                    conv_prog[j] <= '{busy: 1'b0, left: ~conv_prog[j].left};
            end
        end
    end
endmodule : ctwc_conv_model

/* tb/ctwc_top_tb.sv */
`timescale 1ns/1ns
module ctwc_top_tb
    import ctwc_pkg::*;
;
    logic clk_sys;
    logic rst;
    ctwc_bus_t bus;
    logic [31:0] rd_data;
    logic [CTWC_NTRG-1:0] trig_in;
    logic scan_trig_in;
    ctwc_prog_t [CTWC_NEI-1:0] conv_prog;
    logic [CTWC_NEI-1:0] result_read;
    logic [CTWC_NCORE-1:0] core_tick;
    logic [CTWC_NTRG-1:0] conv_start;
    logic scan_start;
    logic [CTWC_NCORE-1:0] warmup_ready;
    logic [CTWC_NEI-1:0] early_ready;
    logic irq;
    logic [CTWC_NCORE-1:0] tick_en;
    logic [CTWC_NEI-1:0] go;
    int bad_count;
    int tests_run;
    int c;
    logic [31:0] v;
    ctwc_top #(.DEDICATED(13'h0001)) ctwc_top_inst (.clk_sys(clk_sys),
        .rst(rst), .bus(bus), .rd_data(rd_data), .trig_in(trig_in),
        .scan_trig_in(scan_trig_in), .conv_prog(conv_prog),
        .result_read(result_read), .core_tick(core_tick),
        .conv_start(conv_start), .scan_start(scan_start),
        .warmup_ready(warmup_ready), .early_ready(early_ready), .irq(irq));
    ctwc_conv_model ctwc_conv_model_inst (.clk_sys(clk_sys), .rst(rst),
        .tick_en(tick_en), .go(go), .core_tick(core_tick),
        .conv_prog(conv_prog));
    ////////////////////////////////////////////////////////////////////////
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    task idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd
    // Holds one trigger high for n cycles, counts the starts it causes
    task hold(input logic scan, input int n, output int cnt);
        cnt = 0;
        for (int i = 0; i < n + 3; i++)
        begin
            @(posedge clk_sys);
            if (scan)
                scan_trig_in <= (i < n);
            else
                trig_in[0] <= (i < n);
            #1;
            cnt += scan ? int'(scan_start) : int'(conv_start[0]);
        end
    endtask : hold
    task ticks(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            tick_en <= '1;
        end
        @(posedge clk_sys);
        tick_en <= '0;
        idle(3);
    endtask : ticks
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        #1000000;
        bad_count++;
        summarize();
    end
    initial
    begin
        bus = '0;
        trig_in = '0;
        scan_trig_in = 1'b0;
        result_read = '0;
        tick_en = '0;
        go = '0;
        bad_count = 0;
        tests_run = 0;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(CTWC_OFS_SNS, v); check(v, 32'h0);
        rd(CTWC_OFS_EIST, v); check(v, 32'h0);
        rd(CTWC_OFS_ANCON, v); check(v, 32'h0);
        rd(8'h40, v); check(v, 32'h0);
        wr(CTWC_OFS_SNS, 32'hFFFFFFFF);
        rd(CTWC_OFS_SNS, v); check(v, 32'h00000FFF);
        wr(CTWC_OFS_SNS, 32'h0);
        hold(1'b0, 4, c); check(c, 32'h1);
        wr(CTWC_OFS_SNS, 32'h1);
        hold(1'b0, 4, c); check(c, 32'h4);
        hold(1'b1, 4, c); check(c, 32'h1);
        wr(CTWC_OFS_SCTL, 32'h1);
        hold(1'b1, 4, c); check(c, 32'h4);
        wr(CTWC_OFS_IMASK, 32'h00042001);
        wr(CTWC_OFS_ANCON, 32'h00810081);
        ticks(15); check(warmup_ready, 6'h00);
        ticks(1); check(warmup_ready, 6'h21);
        check(irq, 1'b1);
        rd(CTWC_OFS_ANCON, v); check(v, 32'h00818181);
        rd(CTWC_OFS_ISTAT, v); check(v, 32'h00042000);
        wr(CTWC_OFS_ISTAT, 32'h00042000);
        idle(2); check(irq, 1'b0);
        wr(CTWC_OFS_ANCON, 32'h0);
        idle(2); check(warmup_ready, 6'h00);
        wr(CTWC_OFS_ANCON, 32'h05000002);
        ticks(31); check(warmup_ready, 6'h00);
        ticks(1); check(warmup_ready, 6'h02);
        wr(CTWC_OFS_ANCON, 32'h00000004);
        ticks(10);
        wr(CTWC_OFS_ANCON, 32'h0);
        wr(CTWC_OFS_ANCON, 32'h00000004);
        ticks(15); check(warmup_ready, 6'h00);
        ticks(1); check(warmup_ready, 6'h04);
        wr(CTWC_OFS_ANCON, 32'h0);
        // Only core 0 steps; core 1 is enabled but its clock stands still
        wr(CTWC_OFS_ANCON, 32'h00000003);
        repeat (16)
        begin
            @(posedge clk_sys);
            tick_en <= 6'h01;
        end
        @(posedge clk_sys);
        tick_en <= 6'h00;
        idle(3); check(warmup_ready, 6'h01);
        wr(CTWC_OFS_ANCON, 32'h0);
        // Core 0 select 2 is reached, shared select 6 is not
        wr(CTWC_OFS_TSEL, 32'h00030002);
        wr(CTWC_OFS_EIEN, 32'h3);
        @(posedge clk_sys);
        go <= 13'h0003;
        @(posedge clk_sys);
        go <= '0;
        idle(10); check(early_ready, 13'h0001);
        rd(CTWC_OFS_EIST, v); check(v, 32'h1);
        check(irq, 1'b1);
        wr(CTWC_OFS_TSEL, 32'h00008002);
        @(posedge clk_sys);
        go <= 13'h0002;
        @(posedge clk_sys);
        go <= '0;
        c = 0;
        while (early_ready[1] !== 1'b1 && c < 20)
        begin
            idle(1);
            c++;
        end
        if (c >= 20)
        begin
            bad_count++;
            summarize();
        end
        check(early_ready, 13'h0003);
        rd(CTWC_OFS_ISTAT, v); check(v, 32'h3);
        wr(CTWC_OFS_IMASK, 32'h00042000);
        idle(2); check(irq, 1'b0);
        @(posedge clk_sys);
        result_read <= 13'h0003;
        @(posedge clk_sys);
        result_read <= '0;
        idle(2); check(early_ready, 13'h0000);
        summarize();
    end
endmodule : ctwc_top_tb
